// [inc/dual_serial_host_port_pkg.sv]
// Types of the dual SPI / I2C host serial port.
`default_nettype none

package dual_serial_host_port_pkg;

   typedef enum logic [2:0] {
      I_IDLE,
      I_RX,
      I_ACKSET,
      I_ACKHOLD,
      I_TX,
      I_MACK,
      I_MLOAD
   } i2c_state_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [2:0]  scl_p;
      logic [2:0]  sda_p;
      logic [2:0]  ce_p;
      logic [1:0]  sel_p;
      logic [15:0] spi_sh;
      logic [4:0]  spi_cnt;
      logic        spi_rd;
      logic [7:0]  tx;
      i2c_state_t  ist;
      logic [3:0]  bitc;
      logic [1:0]  phase;
      logic        rw;
      logic [7:0]  sh;
      logic        mism_scl;
      logic        mism_sda;
      logic        sda_oe_n;
      logic        serial_data_out;
      logic        busy;
      reg_req_t    req;
   } port_state_t;

endpackage

`default_nettype wire

// [inc/dual_serial_host_port_regs.svh]
// Constants of the dual SPI / I2C host serial port.
`ifndef DUAL_SERIAL_HOST_PORT_REGS_SVH
`define DUAL_SERIAL_HOST_PORT_REGS_SVH

// SPI frame: one direction bit, seven address bits, eight data bits.
`define SPI_FRAME_BITS    5'h10
`define SPI_ADDR_LAST     5'h07
`define SPI_DATA_LAST     5'h0F
`define SPI_DATA_FIRST    5'h08

// I2C byte length and slave address upper five bits.
`define I2C_BYTE_LAST     4'h7
`define I2C_BYTE_BITS     4'h8
`define I2C_ADDR_BASE     5'h15

// Address select encodings for tied to SCL and tied to SDA.
`define ASEL_SCL          2'h2
`define ASEL_SDA          2'h3

// Value returned when a read addresses the pattern memory.
`define RAM_READ_VALUE    8'h00

`endif

// [src/dual_serial_host_port.sv]
// Host serial port: pin-selected SPI slave or I2C slave onto the control registers.
`timescale 1ns/1ps
`default_nettype none
`include "dual_serial_host_port_regs.svh"

module dual_serial_host_port
   import dual_serial_host_port_pkg::*;
(
   input  wire logic       I_CLK,        // Core clock, 100 MHz.
   input  wire logic       I_RESETN,     // Synchronous reset, active low.
   input  wire logic       I_IF_SEL,     // Interface select pin, high is SPI.
   input  wire logic       I_CE_ASEL,    // Chip enable or address select pin.
   input  wire logic       I_SCL,        // Serial clock pin.
   input  wire logic       I_SDA,        // Serial data pin level.
   input  wire logic       I_AUTO_INC,   // Sub-address auto-increment setting.
   input  wire logic [7:0] I_REG_RDATA,  // Register contents at O_REG.addr.
   input  wire logic       I_REG_IS_RAM, // O_REG.addr selects pattern memory.
   output logic            O_SDA_O,      // SDA drive level, always low.
   output logic            O_SDA_OE_N,   // SDA pulled low while this is low.
   output logic            O_SDO,        // Serial data out.
   output logic            O_BUSY,       // I2C bus busy.
   output var reg_req_t    O_REG         // Register write strobe and address.
);

   port_state_t r_reg;
   port_state_t r_next;
   logic        scl;
   logic        sda;
   logic        ce;
   logic        scl_rise;
   logic        scl_fall;
   logic        i2c_start;
   logic        i2c_stop;
   logic [6:0]  own_addr;
   logic [7:0]  rd_value;

   // Only the second synchroniser stage and the delayed copy feed logic.
   assign scl       = r_reg.scl_p[1];
   assign sda       = r_reg.sda_p[1];
   assign ce        = r_reg.ce_p[1];
   assign scl_rise  = scl & ~r_reg.scl_p[2];
   assign scl_fall  = ~scl & r_reg.scl_p[2];
   assign i2c_start = scl & r_reg.scl_p[2] & ~sda & r_reg.sda_p[2];
   assign i2c_stop  = scl & r_reg.scl_p[2] & sda & ~r_reg.sda_p[2];

   // A pin that never disagreed with SCL or SDA since the last STOP is tied to it.
   assign own_addr = {`I2C_ADDR_BASE,
                      !r_reg.mism_scl ? `ASEL_SCL :
                      !r_reg.mism_sda ? `ASEL_SDA : {1'b0, ce}};

   // Pattern memory is masked so that reads only reveal control registers.
   assign rd_value = I_REG_IS_RAM ? `RAM_READ_VALUE : I_REG_RDATA;

   always_comb begin
      r_next          = r_reg;
      r_next.scl_p    = {r_reg.scl_p[1:0], I_SCL};
      r_next.sda_p    = {r_reg.sda_p[1:0], I_SDA};
      r_next.ce_p     = {r_reg.ce_p[1:0], I_CE_ASEL};
      r_next.sel_p    = {r_reg.sel_p[0], I_IF_SEL};
      r_next.req.we   = 1'b0;
      if (r_reg.sel_p[1]) begin
         // SPI slave. SDA is only an input here.
         r_next.sda_oe_n = 1'b1;
         r_next.busy     = 1'b0;
         r_next.ist      = I_IDLE;
         if (!ce) begin
            r_next.spi_cnt = 5'h00;
            r_next.serial_data_out     = 1'b0;
         end else if (scl_rise && r_reg.spi_cnt != `SPI_FRAME_BITS) begin
            r_next.spi_sh  = {r_reg.spi_sh[14:0], sda};
            r_next.spi_cnt = r_reg.spi_cnt + 5'h01;
            if (r_reg.spi_cnt == 5'h00) begin
               r_next.spi_rd = sda;
            end
            if (r_reg.spi_cnt == `SPI_ADDR_LAST) begin
               // The direction bit is dropped; the top bit of the address byte is zero.
               r_next.req.addr = {1'b0, r_reg.spi_sh[5:0], sda};
            end
            if (r_reg.spi_cnt == `SPI_DATA_LAST && !r_reg.spi_rd) begin
               r_next.req.we    = 1'b1;
               r_next.req.wdata = {r_reg.spi_sh[6:0], sda};
            end
         end else if (scl_fall && r_reg.spi_rd) begin
            if (r_reg.spi_cnt == `SPI_DATA_FIRST) begin
               r_next.serial_data_out = rd_value[7];
               r_next.tx  = {rd_value[6:0], 1'b0};
            end else if (r_reg.spi_cnt > `SPI_DATA_FIRST &&
                         r_reg.spi_cnt < `SPI_FRAME_BITS) begin
               r_next.serial_data_out = r_reg.tx[7];
               r_next.tx  = {r_reg.tx[6:0], 1'b0};
            end else begin
               r_next.serial_data_out = 1'b0;
            end
         end
      end else begin
         // I2C slave. SCL is never driven, SDA only pulled low.
         r_next.serial_data_out     = 1'b0;
         r_next.spi_cnt = 5'h00;
         r_next.spi_rd  = 1'b0;
         if (ce != scl) begin
            r_next.mism_scl = 1'b1;
         end
         if (ce != sda) begin
            r_next.mism_sda = 1'b1;
         end
         if (i2c_start) begin
            r_next.busy     = 1'b1;
            r_next.ist      = I_RX;
            r_next.bitc     = 4'h0;
            r_next.phase    = 2'h0;
            r_next.sda_oe_n = 1'b1;
         end else if (i2c_stop) begin
            r_next.busy     = 1'b0;
            r_next.ist      = I_IDLE;
            r_next.sda_oe_n = 1'b1;
            r_next.mism_scl = 1'b0;
            r_next.mism_sda = 1'b0;
         end else begin
            case (r_reg.ist)
               I_RX: begin
                  if (scl_rise) begin
                     r_next.sh   = {r_reg.sh[6:0], sda};
                     r_next.bitc = r_reg.bitc + 4'h1;
                     if (r_reg.bitc == `I2C_BYTE_LAST) begin
                        r_next.ist = I_ACKSET;
                     end
                  end
               end
               I_ACKSET: begin
                  if (scl_fall) begin
                     r_next.sda_oe_n = 1'b0;
                     r_next.ist      = I_ACKHOLD;
                     if (r_reg.phase == 2'h0) begin
                        if (r_reg.sh[7:1] == own_addr) begin
                           r_next.rw    = r_reg.sh[0];
                           r_next.phase = 2'h1;
                        end else begin
                           r_next.sda_oe_n = 1'b1;
                           r_next.ist      = I_IDLE;
                        end
                     end else if (r_reg.phase == 2'h1) begin
                        r_next.req.addr = r_reg.sh;
                        r_next.phase    = 2'h2;
                     end else begin
                        r_next.req.we    = 1'b1;
                        r_next.req.wdata = r_reg.sh;
                        r_next.phase     = 2'h3;
                     end
                  end
               end
               I_ACKHOLD: begin
                  if (scl_fall) begin
                     r_next.bitc     = 4'h0;
                     r_next.sda_oe_n = 1'b1;
                     r_next.ist      = I_RX;
                     if (r_reg.phase == 2'h3 && I_AUTO_INC) begin
                        r_next.req.addr = r_reg.req.addr + 8'h01;
                     end
                     if (r_reg.rw) begin
                        // Read from the held sub-address of the last write.
                        r_next.sda_oe_n = rd_value[7];
                        r_next.tx       = {rd_value[6:0], 1'b0};
                        r_next.ist      = I_TX;
                     end
                  end
               end
               I_TX: begin
                  if (scl_rise) begin
                     r_next.bitc = r_reg.bitc + 4'h1;
                  end else if (scl_fall) begin
                     if (r_reg.bitc == `I2C_BYTE_BITS) begin
                        r_next.sda_oe_n = 1'b1;
                        r_next.ist      = I_MACK;
                     end else begin
                        r_next.sda_oe_n = r_reg.tx[7];
                        r_next.tx       = {r_reg.tx[6:0], 1'b0};
                     end
                  end
               end
               I_MACK: begin
                  if (scl_rise) begin
                     if (sda) begin
                        // Master refused the byte: stay off the bus.
                        r_next.ist = I_IDLE;
                     end else begin
                        r_next.ist = I_MLOAD;
                        if (I_AUTO_INC) begin
                           r_next.req.addr = r_reg.req.addr + 8'h01;
                        end
                     end
                  end
               end
               I_MLOAD: begin
                  // Loading at the falling edge gives the register file the
                  // whole SCL high time to settle after an address step.
                  if (scl_fall) begin
                     r_next.sda_oe_n = rd_value[7];
                     r_next.tx       = {rd_value[6:0], 1'b0};
                     r_next.bitc     = 4'h0;
                     r_next.ist      = I_TX;
                  end
               end
               default: begin
                  r_next.ist = I_IDLE;
               end
            endcase
         end
      end
      if (!I_RESETN) begin
         r_next          = '0;
         r_next.ist      = I_IDLE;
         r_next.sda_oe_n = 1'b1;
         // Seeding the pin history at the idle I2C level keeps reset release from
         // showing a false SCL edge; in SPI a seen fall is harmless while CE is low.
         r_next.scl_p    = 3'h7;
         r_next.sda_p    = 3'h7;
      end
   end

   always_ff @(posedge I_CLK) begin
      r_reg <= r_next;
   end

   assign O_SDA_O    = 1'b0;
   assign O_SDA_OE_N = r_reg.sda_oe_n;
   assign O_SDO      = r_reg.serial_data_out;
   assign O_BUSY     = r_reg.busy;
   assign O_REG      = r_reg.req;

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESETN);

   sequence spi_last_bit_s;
      r_reg.sel_p[1] && ce && scl_rise && r_reg.spi_cnt == `SPI_DATA_LAST;
   endsequence

   sequence spi_data_fall_s;
      r_reg.sel_p[1] && ce && scl_fall && r_reg.spi_rd &&
         r_reg.spi_cnt == `SPI_DATA_FIRST;
   endsequence

   sequence addr_match_s;
      !r_reg.sel_p[1] && r_reg.ist == I_ACKSET && scl_fall && !i2c_start &&
         !i2c_stop && r_reg.phase == 2'h0 && r_reg.sh[7:1] == own_addr;
   endsequence

   sequence data_ack_end_s;
      !r_reg.sel_p[1] && r_reg.ist == I_ACKHOLD && scl_fall && !i2c_start &&
         !i2c_stop && r_reg.phase == 2'h3;
   endsequence

   spi_no_sda_a: assert property (
      r_reg.sel_p[1] |=> O_SDA_OE_N)
      else $error("SDA driven in SPI mode.");

   i2c_sdo_low_a: assert property (
      !r_reg.sel_p[1] |=> !O_SDO)
      else $error("Serial data out active in I2C mode.");

   spi_write_a: assert property (
      spi_last_bit_s and !r_reg.spi_rd |=>
         O_REG.we && O_REG.wdata == r_reg.spi_sh[7:0] ##1 !O_REG.we)
      else $error("SPI write frame did not give one write pulse.");

   spi_read_nowr_a: assert property (
      r_reg.sel_p[1] && r_reg.spi_rd && r_reg.spi_cnt != 5'h00 |=> !O_REG.we)
      else $error("SPI read frame wrote a register.");

   spi_shift_a: assert property (
      r_reg.sel_p[1] && ce && scl_rise && r_reg.spi_cnt != `SPI_FRAME_BITS |=>
         r_reg.spi_sh[0] == $past(sda) && r_reg.spi_cnt == $past(r_reg.spi_cnt) + 5'h01)
      else $error("SPI bit not shifted on rising clock.");

   spi_ce_gate_a: assert property (
      r_reg.sel_p[1] && !ce |=> r_reg.spi_cnt == 5'h00 && !O_REG.we)
      else $error("SPI bits taken with chip enable low.");

   spi_read_out_a: assert property (
      spi_data_fall_s |=> O_SDO == $past(rd_value[7]) &&
         (!$past(I_REG_IS_RAM) || (!O_SDO && r_reg.tx == 8'h00)))
      else $error("SPI read data wrong or pattern memory exposed.");

   i2c_busy_a: assert property (
      !r_reg.sel_p[1] && i2c_start |=> O_BUSY ##0 (O_BUSY || i2c_stop)[*2])
      else $error("Bus not busy after START.");

   i2c_free_a: assert property (
      !r_reg.sel_p[1] && i2c_stop |=> !O_BUSY && O_SDA_OE_N)
      else $error("Bus not free after STOP.");

   addr_ack_a: assert property (
      addr_match_s |=> !O_SDA_OE_N && r_reg.ist == I_ACKHOLD)
      else $error("Own slave address not acknowledged.");

   fixed_sub_a: assert property (
      data_ack_end_s and !I_AUTO_INC |=> $stable(O_REG.addr))
      else $error("Fixed sub-address moved.");

   auto_sub_a: assert property (
      data_ack_end_s and I_AUTO_INC |=> O_REG.addr == $past(O_REG.addr) + 8'h01)
      else $error("Auto-increment sub-address did not advance.");

   sequence master_ack_s;
      !r_reg.sel_p[1] && r_reg.ist == I_MACK && scl_rise && !i2c_start &&
         !i2c_stop && !sda;
   endsequence

   read_fixed_a: assert property (
      master_ack_s and !I_AUTO_INC |=> $stable(O_REG.addr))
      else $error("Fixed read sub-address moved.");

   read_auto_a: assert property (
      master_ack_s and I_AUTO_INC |=> O_REG.addr == $past(O_REG.addr) + 8'h01)
      else $error("Auto-increment read sub-address did not advance.");

   sda_owner_a: assert property (
      !O_SDA_OE_N |-> O_BUSY)
      else $error("SDA pulled low outside a transfer.");

   reset_idle_a: assert property (
      @(posedge I_CLK) disable iff (1'h0)
      !I_RESETN |=> O_SDA_OE_N && !O_BUSY && !O_SDO && O_REG == '0)
      else $error("Port not idle after reset.");

endmodule

`default_nettype wire

// [test/dual_serial_host_port_tb.sv]
// Self-checking testbench of the dual SPI / I2C host serial port.
`timescale 1ns/1ps
`default_nettype none
`include "dual_serial_host_port_regs.svh"

module dual_serial_host_port_tb;

   logic                                clk = 1'b0;
   logic                                resetn;
   logic                                if_sel;
   logic                                auto_inc;
   logic                                is_ram;
   logic                                m_scl;
   logic                                m_sda;
   logic                                m_ce;
   logic                                sda_w;
   logic                                ce_asel;
   logic                                sda_o;
   logic                                sda_oe_n;
   logic                                serial_data_out;
   logic                                busy;
   logic [1:0]                          asel_mode;
   logic [7:0]                          rdata;
   logic [7:0]                          regs [0:255];
   dual_serial_host_port_pkg::reg_req_t req;
   int                                  n_errors = 0;
   int                                  tests_run = 0;
   int                                  n_we = 0;

   always #5 clk = ~clk;

   assign sda_w   = (sda_oe_n === 1'b0) ? sda_o : m_sda;
   assign ce_asel = if_sel ? m_ce : (asel_mode == 2'h2) ? m_scl :
                    (asel_mode == 2'h3) ? sda_w : asel_mode[0];
   assign rdata   = regs[req.addr];
   assign is_ram  = (req.addr[7:4] == 4'h6);

   always @(posedge clk) begin
      if (req.we === 1'b1) begin
         regs[req.addr] <= req.wdata;
         n_we <= n_we + 1;
      end
   end

   dual_serial_host_port uut (
      .I_CLK(clk), .I_RESETN(resetn), .I_IF_SEL(if_sel), .I_CE_ASEL(ce_asel),
      .I_SCL(m_scl), .I_SDA(sda_w), .I_AUTO_INC(auto_inc), .I_REG_RDATA(rdata),
      .I_REG_IS_RAM(is_ram), .O_SDA_O(sda_o), .O_SDA_OE_N(sda_oe_n), .O_SDO(serial_data_out),
      .O_BUSY(busy), .O_REG(req)
   );

   host_master_model host (
      .i_sda_line(sda_w), .i_sdo(serial_data_out), .o_scl(m_scl), .o_sda(m_sda), .o_ce(m_ce)
   );

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      if (n_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic spi_scenario;
      logic [7:0] r;
      int         n;
      host.spi_frame({1'b0, 7'h12, 8'h5A}, 16, r);
      chk(regs[8'h12], 8'h5A);
      host.spi_frame({1'b1, 7'h12, 8'h00}, 16, r);
      chk(r, 8'h5A);
      host.spi_frame({1'b1, 7'h60, 8'h00}, 16, r);
      chk(r, `RAM_READ_VALUE);
      n = n_we;
      host.spi_frame({1'b0, 7'h13, 8'hFF}, 12, r);
      chk(8'(n_we - n), 8'h00);
      chk(regs[8'h13], 8'h13 ^ 8'h3C);
      host.spi_frame({1'h0, 7'h13, 8'hA5}, 16, r);
      chk(regs[8'h13], 8'hA5);
   endtask

   task automatic mode_scenario;
      logic [7:0] r;
      int         n;
      if_sel = 1'b0;
      #200;
      n = n_we;
      host.spi_frame({1'b0, 7'h14, 8'hEE}, 16, r);
      chk(8'(n_we - n), 8'h00);
   endtask

   task automatic i2c_send(input logic [7:0] b, input logic exp_ack);
      logic [7:0] r;
      logic       a;
      host.i2c_byte(b, 1'b1, r, a);
      chk({7'h00, a}, {7'h00, exp_ack});
   endtask

   task automatic i2c_get(input logic last, input logic [7:0] exp);
      logic [7:0] r;
      logic       a;
      host.i2c_byte(8'hFF, last, r, a);
      chk(r, exp);
   endtask

   task automatic addr_scenario;
      logic [6:0] sa;
      for (int m = 0; m < 4; m++) begin
         asel_mode = 2'(m);
         sa = 7'b1010100 + 7'(m);
         host.i2c_start();
         i2c_send({7'b1010100 + 7'((m + 1) % 4), 1'b0}, 1'b1);
         host.i2c_start();
         i2c_send({sa, 1'b0}, 1'b0);
         chk({7'h00, busy}, 8'h01);
         i2c_send(8'h20 + 8'(m), 1'b0);
         i2c_send(8'hC0 + 8'(m), 1'b0);
         chk({6'h00, sda_o, serial_data_out}, 8'h00);
         host.i2c_stop();
         chk({7'h00, busy}, 8'h00);
         chk(regs[8'h20 + 8'(m)], 8'hC0 + 8'(m));
      end
      asel_mode = 2'h0;
   endtask

   task automatic i2c_write(input logic [7:0] sub, input logic [7:0] d0, input logic [7:0] d1);
      host.i2c_start();
      i2c_send(8'hA8, 1'b0);
      i2c_send(sub, 1'b0);
      i2c_send(d0, 1'b0);
      i2c_send(d1, 1'b0);
      host.i2c_stop();
   endtask

   task automatic read_sub(input logic [7:0] sub, input logic [7:0] e0, input logic [7:0] e1);
      host.i2c_start();
      i2c_send(8'hA8, 1'b0);
      i2c_send(sub, 1'b0);
      host.i2c_start();
      i2c_send(8'hA9, 1'b0);
      i2c_get(1'b0, e0);
      i2c_get(1'b1, e1);
      host.i2c_stop();
   endtask

   task automatic write_read_scenario;
      auto_inc = 1'b0;
      i2c_write(8'h30, 8'h11, 8'h22);
      chk(regs[8'h30], 8'h22);
      chk(regs[8'h31], 8'h31 ^ 8'h3C);
      auto_inc = 1'b1;
      i2c_write(8'h40, 8'h33, 8'h44);
      chk(regs[8'h40], 8'h33);
      chk(regs[8'h41], 8'h44);
      auto_inc = 1'b0;
      i2c_write(8'h50, 8'h77, 8'h77);
      host.i2c_start();
      i2c_send(8'hA9, 1'b0);
      i2c_get(1'b0, 8'h77);
      i2c_get(1'b1, 8'h77);
      host.i2c_stop();
      read_sub(8'h40, 8'h33, 8'h33);
      auto_inc = 1'b1;
      read_sub(8'h40, 8'h33, 8'h44);
   endtask

   // Reset in mid-transfer must free the bus and clear the held sub-address.
   task automatic reset_scenario;
      host.i2c_start();
      i2c_send(8'hA8, 1'h0);
      chk({7'h00, busy}, 8'h01);
      resetn = 1'h0;
      repeat (3) @(posedge clk);
      #1;
      chk({4'h0, busy, sda_oe_n, serial_data_out, req.we}, 8'h04);
      chk(req.addr, 8'h00);
      resetn = 1'h1;
      repeat (4) @(posedge clk);
      #1;
      host.i2c_stop();
      host.i2c_start();
      i2c_send(8'hA9, 1'h0);
      i2c_get(1'h1, 8'h3C);
      host.i2c_stop();
   endtask

   initial begin
      resetn    = 1'b0;
      if_sel    = 1'b1;
      auto_inc  = 1'b0;
      asel_mode = 2'h0;
      for (int i = 0; i < 256; i++)
         regs[i] = 8'(i) ^ 8'h3C;
      repeat (6) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      spi_scenario();
      mode_scenario();
      addr_scenario();
      write_read_scenario();
      reset_scenario();
      report_and_stop();
   end

   // Cuts a hang short; running out counts as a mismatch.
   initial begin
      #600000;
      n_errors++;
      report_and_stop();
   end

endmodule

`default_nettype wire

// [test/host_master_model.sv]
// Host-side master model that drives the port as an SPI or I2C master.
`timescale 1ns/1ps
`default_nettype none

module host_master_model (
   input  wire logic i_sda_line, // Resolved SDA level.
   input  wire logic i_sdo,      // Serial data out of the port.
   output logic      o_scl,      // Serial clock, still outside frames.
   output logic      o_sda,      // Data level, high is released in I2C.
   output logic      o_ce        // SPI chip enable.
);

   initial begin
      o_scl = 1'b0;
      o_sda = 1'b1;
      o_ce  = 1'b0;
   end

   // A count below 16 cuts the frame short, which must write nothing.
   task automatic spi_frame(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      o_ce = 1'b1;
      for (int i = 0; i < nbits; i++) begin
         o_sda = tx[15 - i];
         #40 o_scl = 1'b1;
         if (i > 7)
            rx[15 - i] = i_sdo;
         #80 o_scl = 1'b0;
         #40;
      end
      o_ce = 1'b0;
      // A released data line must not keep showing its last bit.
      o_sda = ~o_sda;
      #200;
   endtask

   // Data changes only while SCL is low, so no false START or STOP is formed.
   task automatic i2c_bit(input logic b, output logic r);
      o_sda = b;
      #60 o_scl = 1'b1;
      #40 r = i_sda_line;
      #40 o_scl = 1'b0;
      #20;
   endtask

   task automatic i2c_byte(input logic [7:0] b, input logic ack_in, output logic [7:0] r,
                           output logic ack);
      for (int i = 7; i >= 0; i--)
         i2c_bit(b[i], r[i]);
      i2c_bit(ack_in, ack);
   endtask

   task automatic i2c_start;
      o_sda = 1'b1;
      #60 o_scl = 1'b1;
      #40 o_sda = 1'b0;
      #40 o_scl = 1'b0;
      #20;
   endtask

   task automatic i2c_stop;
      o_sda = 1'b0;
      #60 o_scl = 1'b1;
      #40 o_sda = 1'b1;
      #100;
   endtask

endmodule

`default_nettype wire
